// ===== src/bccd_pkg.sv
// Constants shared by the branch, call and clear decode block.
package bccd_pkg;

  // ***************************************************************
  // Opcode patterns
  // ***************************************************************
  localparam logic [7:0] OP_BRANCH_ON_OVERFLOW = 8'hE4;
  localparam logic [7:0] OP_BRANCH_ON_ZERO = 8'hE0;
  localparam logic [6:0] OP_CALL_FIRST = 7'h76;
  localparam logic [3:0] OP_CALL_SECOND = 4'hF;
  localparam logic [6:0] OP_CLEAR_FILE_REGISTER = 7'h35;
  localparam int CALL_SAVE_BIT = 8;
  localparam int ACCESS_BIT = 8;

  // ***************************************************************
  // Addressing
  // ***************************************************************
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_UPPER_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOWER_BANK = 4'h0;

  // ***************************************************************
  // Program counter and return stack
  // ***************************************************************
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] CALL_RETURN_STEP = 21'h000004;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [4:0] STACK_LAST = 5'h1F;

  // ***************************************************************
  // Status register fields
  // ***************************************************************
  localparam int STATUS_ZERO = 2;
  localparam int STATUS_OVERFLOW = 3;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // ***************************************************************
  // APB register offsets and fields
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_WORKING = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'h10;
  localparam logic [7:0] ADDR_WORKING_SHADOW = 8'h14;
  localparam logic [7:0] ADDR_FLAGS_SHADOW = 8'h18;
  localparam logic [7:0] ADDR_BANK_SELECT_SHADOW = 8'h1C;
  localparam logic [7:0] ADDR_TOP_OF_STACK = 8'h20;
  localparam logic [7:0] ADDR_STACK = 8'h24;
  localparam int CTRL_EXTENDED = 0;
  localparam int STACK_OVERFLOW_BIT = 8;

endpackage : bccd_pkg

// ===== src/bccd_stack_mem.sv
// Return stack storage with a registered read port.
`timescale 1ns/1ps
module bccd_stack_mem
(
  // Clock
  input wire logic pclk,
  // Write port
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [20:0] wdata,
  // Read port
  input wire logic [4:0] raddr,
  output logic [20:0] rdata
);

  logic [20:0] mem [0:31];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk)
  begin
    rdata <= mem[raddr];
  end

endmodule : bccd_stack_mem

// ===== src/bccd_core.sv
// Decode and execute of the overflow and zero branches, the call and the file clear.
`timescale 1ns/1ps

module bccd_core
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr_data,
  output logic instr_ready,
  // Register file side
  input wire logic [11:0] index_base,
  output logic file_clear_we,
  output logic [11:0] file_clear_addr,
  output logic [20:0] pc_out
);

  typedef enum logic [2:0]
  {
    ST_EXEC = 3'b001,
    ST_CALL2 = 3'b010,
    ST_FLUSH = 3'b100
  } bccd_state_e;

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic logic [20:0] branch_target(input logic [20:0] pc_now, input logic [7:0] offs);
    branch_target = pc_now + bccd_pkg::PC_STEP + {{12{offs[7]}}, offs, 1'b0};
  endfunction : branch_target

  function automatic logic [11:0] clear_address(input logic abit, input logic ext, input logic [7:0] f,
                                                input logic [3:0] bank, input logic [11:0] base);
    if (abit)
    begin
      clear_address = {bank, f};
    end
    else if (ext && (f <= bccd_pkg::INDEXED_LIMIT))
    begin
      clear_address = base + {4'h0, f};
    end
    else if (f <= bccd_pkg::INDEXED_LIMIT)
    begin
      clear_address = {bccd_pkg::ACCESS_LOWER_BANK, f};
    end
    else
    begin
      clear_address = {bccd_pkg::ACCESS_UPPER_BANK, f};
    end
  endfunction : clear_address

  // ***************************************************************
  // State
  // ***************************************************************
  bccd_state_e state;
  bccd_state_e next_state;
  logic [20:0] pc;
  logic [20:0] next_pc;
  logic [7:0] working;
  logic [7:0] next_working;
  logic [4:0] status;
  logic [4:0] next_status;
  logic [3:0] bank_select_register;
  logic [7:0] working_shadow;
  logic [4:0] flags_shadow;
  logic [3:0] bank_select_shadow;
  logic [4:0] sp;
  logic stack_overflow;
  logic ctrl_extended;
  logic [7:0] call_low;
  logic [20:0] stack_rdata;

  // ***************************************************************
  // Decode
  // ***************************************************************
  wire accept = instr_valid && instr_ready;
  wire in_exec = accept && (state == ST_EXEC);
  wire is_bov = instr_data[15:8] == bccd_pkg::OP_BRANCH_ON_OVERFLOW;
  wire is_bz = instr_data[15:8] == bccd_pkg::OP_BRANCH_ON_ZERO;
  wire is_call = instr_data[15:9] == bccd_pkg::OP_CALL_FIRST;
  wire is_clear = instr_data[15:9] == bccd_pkg::OP_CLEAR_FILE_REGISTER;
  wire cond_true = (is_bov && status[bccd_pkg::STATUS_OVERFLOW]) || (is_bz && status[bccd_pkg::STATUS_ZERO]);
  wire branch_taken = in_exec && cond_true;
  wire call_first = in_exec && is_call;
  wire call_second = accept && (state == ST_CALL2);
  wire clear_exec = in_exec && is_clear;
  wire save_bit = instr_data[bccd_pkg::CALL_SAVE_BIT];
  wire [20:0] taken_pc = branch_target(pc, instr_data[7:0]);
  wire [20:0] call_pc = {instr_data[11:0], call_low, 1'b0};
  wire [11:0] clear_addr = clear_address(instr_data[bccd_pkg::ACCESS_BIT], ctrl_extended, instr_data[7:0],
                                         bank_select_register, index_base);
  wire stack_full = sp == bccd_pkg::STACK_LAST;
  wire stack_push = call_first && !stack_full;

  // ***************************************************************
  // APB decode
  // ***************************************************************
  wire apb_write = psel && penable && pwrite;
  wire wr_ctrl = apb_write && (paddr == bccd_pkg::ADDR_CTRL);
  wire wr_pc = apb_write && (paddr == bccd_pkg::ADDR_PC);
  wire wr_working = apb_write && (paddr == bccd_pkg::ADDR_WORKING);
  wire wr_status = apb_write && (paddr == bccd_pkg::ADDR_STATUS);
  wire wr_bank = apb_write && (paddr == bccd_pkg::ADDR_BANK_SELECT);
  wire wr_stack = apb_write && (paddr == bccd_pkg::ADDR_STACK);
  wire [20:0] top_of_return_stack = (sp == 5'h00) ? 21'h000000 : stack_rdata;
  wire [31:0] rd_mux =
    (paddr == bccd_pkg::ADDR_CTRL) ? {31'h00000000, ctrl_extended} :
    (paddr == bccd_pkg::ADDR_PC) ? {11'h000, pc} :
    (paddr == bccd_pkg::ADDR_WORKING) ? {24'h000000, working} :
    (paddr == bccd_pkg::ADDR_STATUS) ? {27'h0000000, status} :
    (paddr == bccd_pkg::ADDR_BANK_SELECT) ? {28'h0000000, bank_select_register} :
    (paddr == bccd_pkg::ADDR_WORKING_SHADOW) ? {24'h000000, working_shadow} :
    (paddr == bccd_pkg::ADDR_FLAGS_SHADOW) ? {27'h0000000, flags_shadow} :
    (paddr == bccd_pkg::ADDR_BANK_SELECT_SHADOW) ? {28'h0000000, bank_select_shadow} :
    (paddr == bccd_pkg::ADDR_TOP_OF_STACK) ? {11'h000, top_of_return_stack} :
    {23'h000000, stack_overflow, 3'h0, sp};
  wire addr_hit = (paddr <= bccd_pkg::ADDR_STACK) && (paddr[1:0] == 2'h0);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = (psel && !pwrite && addr_hit) ? rd_mux : 32'h00000000;
  assign instr_ready = state != ST_FLUSH;
  assign pc_out = pc;

  // ***************************************************************
  // Next values
  // ***************************************************************
  assign next_state = (branch_taken || call_second) ? ST_FLUSH :
                      call_first ? ST_CALL2 :
                      (state == ST_FLUSH) ? ST_EXEC : state;
  assign next_pc = call_second ? call_pc :
                   branch_taken ? taken_pc :
                   in_exec && !is_call ? pc + bccd_pkg::PC_STEP :
                   wr_pc ? pwdata[20:0] : pc;
  assign next_working = wr_working ? pwdata[7:0] : working;

  always_comb
  begin
    next_status = wr_status ? pwdata[4:0] : status;
    if (clear_exec)
    begin
      next_status[bccd_pkg::STATUS_ZERO] = 1'b1;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_EXEC;
      pc <= bccd_pkg::PC_RESET;
      working <= 8'h00;
      status <= bccd_pkg::STATUS_RESET;
      bank_select_register <= 4'h0;
      ctrl_extended <= 1'b0;
      call_low <= 8'h00;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      working <= next_working;
      status <= next_status;
      bank_select_register <= wr_bank ? pwdata[3:0] : bank_select_register;
      ctrl_extended <= wr_ctrl ? pwdata[bccd_pkg::CTRL_EXTENDED] : ctrl_extended;
      call_low <= call_first ? instr_data[7:0] : call_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      working_shadow <= 8'h00;
      flags_shadow <= 5'h00;
      bank_select_shadow <= 4'h0;
    end
    else if (call_first && save_bit)
    begin
      working_shadow <= working;
      flags_shadow <= status;
      bank_select_shadow <= bank_select_register;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp <= 5'h00;
      stack_overflow <= 1'b0;
    end
    else
    begin
      sp <= stack_push ? sp + 5'h01 : sp;
      stack_overflow <= (call_first && stack_full) || (stack_overflow &&
                        !(wr_stack && pwdata[bccd_pkg::STACK_OVERFLOW_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      file_clear_we <= 1'b0;
      file_clear_addr <= 12'h000;
    end
    else
    begin
      file_clear_we <= clear_exec;
      file_clear_addr <= clear_exec ? clear_addr : file_clear_addr;
    end
  end

  bccd_stack_mem u_stack
  (
    .pclk(pclk),
    .we(stack_push),
    .waddr(sp),
    .wdata(pc + bccd_pkg::CALL_RETURN_STEP),
    .raddr(sp - 5'h01),
    .rdata(stack_rdata)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_taken;
    branch_taken;
  endsequence

  sequence s_flush_then_exec;
    (state == ST_FLUSH) && !instr_ready ##1 (state == ST_EXEC);
  endsequence

  a_bov_not_taken: assert property (in_exec && is_bov && !status[bccd_pkg::STATUS_OVERFLOW] && !wr_pc
    |=> pc == $past(pc) + bccd_pkg::PC_STEP && state == ST_EXEC)
    else $error("overflow branch moved wrongly when clear");
  a_bz_not_taken: assert property (in_exec && is_bz && !status[bccd_pkg::STATUS_ZERO]
    |=> pc == $past(pc) + bccd_pkg::PC_STEP && state == ST_EXEC)
    else $error("zero branch moved wrongly when clear");
  a_branch_target: assert property (s_taken
    |=> pc == $past(pc) + bccd_pkg::PC_STEP + {{12{$past(instr_data[7])}}, $past(instr_data[7:0]), 1'b0})
    else $error("taken branch target wrong");
  a_branch_flush: assert property (s_taken |=> s_flush_then_exec)
    else $error("taken branch lacks one nop cycle");
  a_branch_flags: assert property (in_exec && (is_bov || is_bz) && !wr_status |=> status == $past(status))
    else $error("branch changed status");
  a_call_push: assert property (stack_push ##1 !call_first [*1]
    |-> ##1 top_of_return_stack == $past(pc, 2) + bccd_pkg::CALL_RETURN_STEP)
    else $error("return address on stack wrong");
  a_shadow_save: assert property (call_first && save_bit
    |=> working_shadow == $past(working) && flags_shadow == $past(status)
    && bank_select_shadow == $past(bank_select_register))
    else $error("shadow save missing");
  a_shadow_hold: assert property (call_first && !save_bit
    |=> $stable(working_shadow) && $stable(flags_shadow) && $stable(bank_select_shadow))
    else $error("shadow changed without save bit");
  a_call_load: assert property (call_first ##1 call_second
    |=> pc == {$past(instr_data[11:0]), $past(instr_data[7:0], 2), 1'b0} ##1 state == ST_EXEC)
    else $error("call target or timing wrong");
  a_clear_zero: assert property (clear_exec |=> file_clear_we && status[bccd_pkg::STATUS_ZERO])
    else $error("clear did not write or set zero");
  a_clear_banked: assert property (clear_exec && instr_data[bccd_pkg::ACCESS_BIT]
    |=> file_clear_addr == {$past(bank_select_register), $past(instr_data[7:0])})
    else $error("banked clear address wrong");
  a_clear_indexed: assert property (clear_exec && !instr_data[bccd_pkg::ACCESS_BIT] && ctrl_extended
    && instr_data[7:0] <= bccd_pkg::INDEXED_LIMIT
    |=> file_clear_addr == $past(index_base) + {4'h0, $past(instr_data[7:0])})
    else $error("indexed clear address wrong");
  a_clear_single: assert property (clear_exec |=> state == ST_EXEC && instr_ready)
    else $error("clear took more than one cycle");

endmodule : bccd_core

// ===== verif/branch_call_clear_decode_bench.sv
// Self-checking testbench for the branch, call and clear decode block.
`timescale 1ns/1ps
module branch_call_clear_decode_bench;

  // ***************************************************************
  // Signals
  // ***************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic instr_valid, instr_ready, file_clear_we;
  logic [15:0] instr_data;
  logic [11:0] index_base, file_clear_addr;
  logic [20:0] pc_out;
  int errors, cmp_count;
  logic [7:0] b_op [5] = '{8'hE0, 8'hE0, 8'hE4, 8'hE4, 8'hE0};
  logic [7:0] b_n [5] = '{8'h05, 8'h80, 8'h7F, 8'h10, 8'h22};
  logic [31:0] b_st [5] = '{32'h0, 32'h4, 32'h8, 32'h4, 32'h8};
  logic b_tk [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [20:0] b_pc [5] = '{21'h001002, 21'h000F02, 21'h001100, 21'h001002, 21'h001002};
  logic [31:0] c_ctl [7] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h1};
  logic [31:0] c_bank [7] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h5, 32'h5};
  logic [15:0] c_word [7] = '{16'h6B20, 16'h6A80, 16'h6A10, 16'h6A10, 16'h6A60, 16'h6B10, 16'h6A5F};
  logic [11:0] c_idx [7] = '{12'h000, 12'h000, 12'h000, 12'h0A0, 12'h0A0, 12'h0A0, 12'h0A0};
  logic [11:0] c_exp [7] = '{12'h320, 12'hF80, 12'h010, 12'h0B0, 12'hF60, 12'h510, 12'h0FF};

  bccd_core i_dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .instr_valid(instr_valid),
    .instr_data(instr_data),
    .instr_ready(instr_ready),
    .index_base(index_base),
    .file_clear_we(file_clear_we),
    .file_clear_addr(file_clear_addr),
    .pc_out(pc_out)
  );

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic end_sim;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
      errors++;
    // Read data and the error flag are taken at the edge that sees pready high.
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  // Presents one instruction word and returns at the edge that takes it.
  task automatic put(input logic [15:0] w);
    int n;
    n = 0;
    instr_valid <= 1'b1;
    instr_data <= w;
    @(posedge pclk);
    while (instr_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
      errors++;
  endtask : put

  task automatic idle;
    instr_valid <= 1'b0;
  endtask : idle

  // ***************************************************************
  // Clock, watchdog and tests
  // ***************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    #300000;
    errors++;
    end_sim();
  end

  initial
  begin
    errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr_data = 16'h0000;
    index_base = 12'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pc_out, 32'h0);
    rd(bccd_pkg::ADDR_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    chk(perr, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      wr(bccd_pkg::ADDR_STATUS, b_st[i]);
      wr(bccd_pkg::ADDR_PC, 32'h00001000);
      put({b_op[i], b_n[i]});
      idle();
      @(negedge pclk);
      chk(pc_out, b_pc[i]);
      chk(instr_ready, !b_tk[i]);
      @(posedge pclk);
      rd(bccd_pkg::ADDR_STATUS, b_st[i]);
    end
    wr(bccd_pkg::ADDR_WORKING, 32'h5A);
    wr(bccd_pkg::ADDR_BANK_SELECT, 32'h3);
    wr(bccd_pkg::ADDR_STATUS, 32'h8);
    wr(bccd_pkg::ADDR_PC, 32'h200);
    put(16'hED34);
    put(16'hF012);
    idle();
    @(negedge pclk);
    chk(pc_out, 32'h2468);
    chk(instr_ready, 1'b0);
    @(posedge pclk);
    rd(bccd_pkg::ADDR_TOP_OF_STACK, 32'h204);
    rd(bccd_pkg::ADDR_STACK, 32'h1);
    rd(bccd_pkg::ADDR_WORKING_SHADOW, 32'h5A);
    rd(bccd_pkg::ADDR_FLAGS_SHADOW, 32'h8);
    rd(bccd_pkg::ADDR_BANK_SELECT_SHADOW, 32'h3);
    wr(bccd_pkg::ADDR_WORKING, 32'h11);
    wr(bccd_pkg::ADDR_STATUS, 32'h0);
    wr(bccd_pkg::ADDR_BANK_SELECT, 32'h6);
    put(16'hEC01);
    put(16'hF000);
    idle();
    @(negedge pclk);
    chk(pc_out, 32'h2);
    @(posedge pclk);
    rd(bccd_pkg::ADDR_TOP_OF_STACK, 32'h246C);
    rd(bccd_pkg::ADDR_WORKING_SHADOW, 32'h5A);
    rd(bccd_pkg::ADDR_FLAGS_SHADOW, 32'h8);
    rd(bccd_pkg::ADDR_BANK_SELECT_SHADOW, 32'h3);
    rd(bccd_pkg::ADDR_STACK, 32'h2);
    // Thirty more calls fill the stack; the last one finds it full and sets the sticky flag.
    for (int i = 0; i < 30; i++)
    begin
      put(16'hEC00);
      put(16'hF000);
    end
    idle();
    rd(bccd_pkg::ADDR_STACK, 32'h11F);
    wr(bccd_pkg::ADDR_STACK, 32'h100);
    rd(bccd_pkg::ADDR_STACK, 32'h1F);
    for (int i = 0; i < 7; i++)
    begin
      wr(bccd_pkg::ADDR_CTRL, c_ctl[i]);
      wr(bccd_pkg::ADDR_BANK_SELECT, c_bank[i]);
      wr(bccd_pkg::ADDR_STATUS, 32'h0);
      index_base <= c_idx[i];
      put(c_word[i]);
      idle();
      @(negedge pclk);
      chk(file_clear_we, 1'b1);
      chk(file_clear_addr, c_exp[i]);
      chk(instr_ready, 1'b1);
      @(negedge pclk);
      chk(file_clear_we, 1'b0);
      @(posedge pclk);
      rd(bccd_pkg::ADDR_STATUS, 32'h4);
    end
    // A reset in mid-run returns the counter to zero and empties the stack.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pc_out, 32'h0);
    rd(bccd_pkg::ADDR_STACK, 32'h0);
    rd(bccd_pkg::ADDR_TOP_OF_STACK, 32'h0);
    end_sim();
  end

endmodule : branch_call_clear_decode_bench
